//--- rtl/sac_dev.sv
// converter end: bus strobes, conversion sequencer, result latch, completion flag
//
// Contract
// - cs and wr low, then release, restarts
// - aborted conversion never loads result latch
// - last completed result stays until next completes
// - free run: cs, rd low, done to wr
// - host pulses done/wr node low after power-up
// - host waits 74 converter clocks before reading
// - host may use done as interrupt request
// - host write strobe with chip select starts
// - host read strobe with chip select reads
// - write data ignored, any write starts
// - unsigned binary, zero code at zero difference
// - full scale reaches all ones code
// - converter clock external or internal oscillator
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_dev
  import sac_pkg::*;
#(
  parameter int RC_DIV = 20                 // system clocks per internal oscillator tick
) (
  input  wire logic       clk_sys,          // system clock, 20 MHz
  input  wire logic       rst,              // async reset, active high
  sac_bus_if.dev          bus,              // microprocessor bus pins
  input  wire sac_code_t  analog_in_pos,    // positive input, digitised level
  input  wire sac_code_t  analog_in_neg,    // negative input, digitised level
  input  wire logic       clk_sel,          // 1 internal oscillator, 0 external clock
  output logic            busy,             // conversion running
  output sac_code_t       result            // copy of output latch
);

  // refuse divider values the oscillator counter cannot hold
  generate
    if (RC_DIV < 2 || RC_DIV > 256) begin : g_bad_div
      $error("sac_dev: RC_DIV must lie in 2..256");
    end
  endgenerate

  localparam logic [7:0] RC_LAST = 8'(RC_DIV - 1); // last oscillator count

  sac_state_t state_reg;                    // sequencer state
  sac_state_t state_next;                   // next sequencer state
  logic [3:0] pin_meta_reg;                 // first sync stage, read only by second
  logic [3:0] pin_sync_reg;                 // second sync stage
  logic       clk_prev_reg;                 // delayed external clock for edge detect
  logic       rd_act_prev_reg;              // previous read access level
  logic [7:0] rc_cnt_reg;                   // internal oscillator divider
  logic [7:0] sub_cnt_reg;                  // ticks left in current step
  logic       setup_reg;                    // still in setup phase
  logic [2:0] bit_idx_reg;                  // bit under trial
  sac_code_t  sar_reg;                      // approximation register
  sac_code_t  result_reg;                   // output data latch
  logic       irq_n_reg;                    // completion flag, active low

  logic       cs_s;                         // synced chip select
  logic       wr_s;                         // synced write strobe
  logic       rd_s;                         // synced read strobe
  logic       hold;                         // select and write both low
  logic       rd_act;                       // select and read both low
  logic       rd_start;                     // first cycle of a read access
  logic       ext_tick;                     // rising edge of external clock
  logic       rc_tick;                      // internal oscillator tick
  logic       tick;                         // selected converter clock tick
  logic       step_end;                     // last tick of a step
  logic       decide;                       // a bit decision is made now
  logic       finish;                       // conversion completes now
  sac_code_t  diff;                         // input difference, floored at zero

  // unsigned difference; negative differences read as the zero code
  function automatic sac_code_t sac_diff(input sac_code_t pos, input sac_code_t neg);
    if (pos >= neg) begin
      return sac_code_t'(pos - neg);
    end
    return `SAC_ZERO_CODE;
  endfunction : sac_diff

  // one successive approximation trial, keeps the bit if not above input
  function automatic sac_code_t sac_decide(input sac_code_t cur,
                                           input logic [2:0] idx,
                                           input sac_code_t din);
    sac_code_t trial;
    trial = cur | sac_code_t'(`SAC_CNT8_ONE << idx);
    return (trial <= din) ? trial : cur;
  endfunction : sac_decide

  // bus pins come from another party, so two flops before any use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= `SAC_PINS_IDLE;
      pin_sync_reg <= `SAC_PINS_IDLE;
      clk_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {bus.cs_n, bus.wr_n, bus.rd_n, bus.conv_clk};
      pin_sync_reg <= pin_meta_reg;
      clk_prev_reg <= pin_sync_reg[`SAC_PIN_CLK];
    end
  end

  assign cs_s     = pin_sync_reg[`SAC_PIN_CS];
  assign wr_s     = pin_sync_reg[`SAC_PIN_WR];
  assign rd_s     = pin_sync_reg[`SAC_PIN_RD];
  // data lines never sampled: any write starts a conversion
  assign hold     = ~cs_s & ~wr_s;
  assign rd_act   = ~cs_s & ~rd_s;
  assign rd_start = rd_act & ~rd_act_prev_reg;
  assign ext_tick = pin_sync_reg[`SAC_PIN_CLK] & ~clk_prev_reg;
  assign diff     = sac_diff(analog_in_pos, analog_in_neg);

  // internal oscillator stands in for the resistor-capacitor clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_cnt_reg <= `SAC_CNT8_ZERO;
    end else if (rc_cnt_reg == RC_LAST) begin
      rc_cnt_reg <= `SAC_CNT8_ZERO;
    end else begin
      rc_cnt_reg <= rc_cnt_reg + `SAC_CNT8_ONE;
    end
  end

  assign rc_tick = (rc_cnt_reg == RC_LAST);
  // clock source choice is static; switching mid conversion may drop a tick
  assign tick    = clk_sel ? rc_tick : ext_tick;

  assign step_end = (state_reg == SAC_CONV) && tick && (sub_cnt_reg == `SAC_CNT8_ZERO);
  assign decide   = step_end && !setup_reg && !hold;
  assign finish   = decide && (bit_idx_reg == `SAC_LSB_IDX);

  // sequencer: a held start strobe aborts whatever runs
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SAC_IDLE: begin
        if (hold) begin
          state_next = SAC_HOLD;
        end
      end
      SAC_HOLD: begin
        if (!hold) begin
          state_next = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (hold) begin
          state_next = SAC_HOLD;
        end else if (finish) begin
          state_next = SAC_IDLE;
        end
      end
      default: begin
        state_next = SAC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= SAC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // step timing: setup phase, then one step per bit, msb first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sub_cnt_reg <= `SAC_CNT8_ZERO;
      setup_reg   <= 1'b1;
      bit_idx_reg <= `SAC_MSB_IDX;
    end else if (state_reg != SAC_CONV || hold) begin
      // reload while waiting, so a restart begins from the top
      sub_cnt_reg <= `SAC_SETUP_TICKS - `SAC_CNT8_ONE;
      setup_reg   <= 1'b1;
      bit_idx_reg <= `SAC_MSB_IDX;
    end else if (step_end) begin
      sub_cnt_reg <= `SAC_TICKS_BIT - `SAC_CNT8_ONE;
      setup_reg   <= 1'b0;
      if (!setup_reg) begin
        bit_idx_reg <= bit_idx_reg - 3'h1;
      end
    end else if (tick) begin
      sub_cnt_reg <= sub_cnt_reg - `SAC_CNT8_ONE;
    end
  end

  // approximation register, cleared on every start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sar_reg <= `SAC_ZERO_CODE;
    end else if (state_reg != SAC_CONV) begin
      sar_reg <= `SAC_ZERO_CODE;
    end else if (decide) begin
      sar_reg <= sac_decide(sar_reg, bit_idx_reg, diff);
    end
  end

  // output latch loads only on a completed conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_reg <= `SAC_RESULT_RST;
    end else if (finish) begin
      // lsb decision folded in here to save a cycle
      result_reg <= sac_decide(sar_reg, bit_idx_reg, diff);
    end
  end
  // otherwise the latch keeps the last good code, aborts included

  // read edge detect for clearing the completion flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_act_prev_reg <= 1'b0;
    end else begin
      rd_act_prev_reg <= rd_act;
    end
  end

  // completion flag: completion wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_n_reg <= 1'b1;
    end else if (finish) begin
      irq_n_reg <= 1'b0;
    end else if (hold || rd_start) begin
      irq_n_reg <= 1'b1;
    end
  end

  // bus outputs; data stays parked on the latch, enable gates the lines
  assign bus.data_out   = result_reg;
  assign bus.data_oe    = rd_act;
  assign bus.done_irq_n = irq_n_reg;
  assign busy           = (state_reg == SAC_CONV);
  assign result         = result_reg;

endmodule : sac_dev

//--- rtl/sac_map.svh
// named constants for the converter control block and its host
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CODE_W        8
`define SAC_ZERO_CODE     8'h00
`define SAC_FULL_CODE     8'hff
`define SAC_RESULT_RST    8'h00
`define SAC_BUS_FLOAT     8'hff
`define SAC_SETUP_TICKS   8'h08
`define SAC_TICKS_BIT     8'h08
`define SAC_MSB_IDX       3'h7
`define SAC_LSB_IDX       3'h0
`define SAC_PINS_IDLE     4'hf
`define SAC_HOST_WAIT     7'h4a
`define SAC_CNT8_ZERO     8'h00
`define SAC_CNT7_ZERO     7'h00
`define SAC_CNT8_ONE      8'h01
`define SAC_CNT7_ONE      7'h01
`define SAC_PIN_CS        3
`define SAC_PIN_WR        2
`define SAC_PIN_RD        1
`define SAC_PIN_CLK       0
`endif

//--- rtl/sac_pkg.sv
// shared types for the converter control block and its host
`include "sac_map.svh"
package sac_pkg;
  // device end conversion sequencer
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_HOLD = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;
  // host end access sequencer
  typedef enum logic [2:0] {
    SAC_H_PWR  = 3'b000,
    SAC_H_IDLE = 3'b001,
    SAC_H_WR   = 3'b010,
    SAC_H_WAIT = 3'b011,
    SAC_H_RD   = 3'b100,
    SAC_H_FREE = 3'b101
  } sac_hstate_t;
  typedef logic [`SAC_CODE_W-1:0] sac_code_t;
endpackage : sac_pkg

//--- rtl/sac_bus_if.sv
// microprocessor bus between converter and host, with resolved data lines
`timescale 1ns/1ps
`include "sac_map.svh"
interface sac_bus_if;
  logic                   cs_n;       // chip select, active low
  logic                   wr_n;       // start strobe, active low
  logic                   rd_n;       // read strobe, active low
  logic                   conv_clk;   // converter clock from host
  logic                   done_irq_n; // completion, active low
  logic                   data_oe;    // device drives data lines
  logic [`SAC_CODE_W-1:0] data_out;   // device output latch
  logic [`SAC_CODE_W-1:0] data_bus;   // resolved bus level
  // pull-ups float the lines high when nobody drives
  assign data_bus = data_oe ? data_out : `SAC_BUS_FLOAT;
  modport dev (input cs_n, input wr_n, input rd_n, input conv_clk,
               output data_out, output data_oe, output done_irq_n);
  modport host (output cs_n, output wr_n, output rd_n, output conv_clk,
                input data_bus, input done_irq_n);
endinterface : sac_bus_if

//--- rtl/sac_host.sv
// host end: start, wait, read sequencer, free-run wiring and converter clock
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_host
  import sac_pkg::*;
#(
  parameter bit FREE_RUN = 1'b0,            // wire for continuous conversion
  parameter bit USE_IRQ  = 1'b0,            // wait on completion instead of counting
  parameter int CLK_HALF = 10,              // system clocks per converter clock half
  parameter int STROBE   = 4,               // strobe length in system clocks
  parameter int PWRUP    = 4                // power-up low pulse in system clocks
) (
  input  wire logic       clk_sys,          // system clock, 20 MHz
  input  wire logic       rst,              // async reset, active high
  sac_bus_if.host         bus,              // microprocessor bus pins
  input  wire logic       start_req,        // one-cycle request: convert and read
  output logic            ready,            // host accepts a request
  output sac_code_t       rd_data,          // last read code
  output logic            rd_valid          // one-cycle pulse with new code
);

  generate
    if (CLK_HALF < 1 || CLK_HALF > 256 || STROBE < 4 || STROBE > 256 ||
        PWRUP < 1 || PWRUP > 256) begin : g_bad_par
      $error("sac_host: parameter out of range");
    end
  endgenerate

  localparam logic [7:0] HALF_LAST = 8'(CLK_HALF - 1);
  localparam logic [7:0] STR_LAST  = 8'(STROBE - 1);
  localparam logic [7:0] PWR_LAST  = 8'(PWRUP - 1);

  sac_hstate_t state_reg;                   // sequencer state
  logic [7:0]  cnt_reg;                     // strobe and pulse length
  logic [7:0]  div_reg;                     // converter clock divider
  logic        cclk_reg;                    // converter clock level
  logic [6:0]  edge_reg;                    // converter clock rises seen
  logic        done_prev_reg;               // previous completion level
  sac_code_t   rd_data_reg;                 // captured code
  logic        rd_valid_reg;                // capture pulse
  logic        cclk_rise;                   // converter clock rises now
  logic        cnt_end;                     // strobe or pulse ends now
  logic        free_done;                   // free-run completion edge

  // converter clock runs free from reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg  <= `SAC_CNT8_ZERO;
      cclk_reg <= 1'b0;
    end else if (div_reg == HALF_LAST) begin
      div_reg  <= `SAC_CNT8_ZERO;
      cclk_reg <= ~cclk_reg;
    end else begin
      div_reg  <= div_reg + `SAC_CNT8_ONE;
    end
  end

  assign cclk_rise = (div_reg == HALF_LAST) && !cclk_reg;
  assign cnt_end   = (state_reg == SAC_H_PWR) ? (cnt_reg == PWR_LAST) : (cnt_reg == STR_LAST);
  assign free_done = (state_reg == SAC_H_FREE) && !bus.done_irq_n && done_prev_reg;

  // sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= FREE_RUN ? SAC_H_PWR : SAC_H_IDLE;
    end else begin
      case (state_reg)
        SAC_H_PWR:  state_reg <= cnt_end ? SAC_H_FREE : SAC_H_PWR;
        SAC_H_IDLE: state_reg <= start_req ? SAC_H_WR : SAC_H_IDLE;
        SAC_H_WR:   state_reg <= cnt_end ? SAC_H_WAIT : SAC_H_WR;
        SAC_H_WAIT: begin
          if (USE_IRQ ? !bus.done_irq_n : (edge_reg >= `SAC_HOST_WAIT)) begin
            state_reg <= SAC_H_RD;
          end
        end
        SAC_H_RD:   state_reg <= cnt_end ? SAC_H_IDLE : SAC_H_RD;
        SAC_H_FREE: state_reg <= SAC_H_FREE;
        default:    state_reg <= SAC_H_IDLE;
      endcase
    end
  end

  // strobe length, restarts whenever the state changes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= `SAC_CNT8_ZERO;
    end else if (cnt_end || state_reg == SAC_H_IDLE || state_reg == SAC_H_WAIT) begin
      cnt_reg <= `SAC_CNT8_ZERO;
    end else begin
      cnt_reg <= cnt_reg + `SAC_CNT8_ONE;
    end
  end

  // converter clock rises counted from the write release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edge_reg <= `SAC_CNT7_ZERO;
    end else if (state_reg != SAC_H_WAIT) begin
      edge_reg <= `SAC_CNT7_ZERO;
    end else if (cclk_rise && edge_reg < `SAC_HOST_WAIT) begin
      edge_reg <= edge_reg + `SAC_CNT7_ONE;
    end
  end

  // capture at end of read strobe, or at each free-run completion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_prev_reg <= 1'b1;
      rd_data_reg   <= `SAC_RESULT_RST;
      rd_valid_reg  <= 1'b0;
    end else begin
      done_prev_reg <= bus.done_irq_n;
      rd_valid_reg  <= 1'b0;
      if ((state_reg == SAC_H_RD && cnt_end) || free_done) begin
        rd_data_reg  <= bus.data_bus;
        rd_valid_reg <= 1'b1;
      end
    end
  end

  // strobes decoded from state; free run ties select and read low
  assign bus.cs_n     = !(state_reg == SAC_H_WR || state_reg == SAC_H_RD ||
                          state_reg == SAC_H_PWR || state_reg == SAC_H_FREE);
  assign bus.wr_n     = (state_reg == SAC_H_FREE) ? bus.done_irq_n :
                        !(state_reg == SAC_H_WR || state_reg == SAC_H_PWR);
  assign bus.rd_n     = !(state_reg == SAC_H_RD || state_reg == SAC_H_PWR ||
                          state_reg == SAC_H_FREE);
  assign bus.conv_clk = cclk_reg;
  assign ready        = (state_reg == SAC_H_IDLE);
  assign rd_data      = rd_data_reg;
  assign rd_valid     = rd_valid_reg;

endmodule : sac_host

//--- verif/sac_monitor.sv
// concurrent checks on the bus between host end and converter end
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_monitor (
  input wire logic                   clk_sys,    // system clock
  input wire logic                   rst,        // async reset, active high
  input wire logic                   cs_n,       // chip select
  input wire logic                   wr_n,       // start strobe
  input wire logic                   rd_n,       // read strobe
  input wire logic                   conv_clk,   // converter clock
  input wire logic                   done_irq_n, // completion flag
  input wire logic                   data_oe,    // device drives lines
  input wire logic [`SAC_CODE_W-1:0] data_out,   // device output latch
  input wire logic [`SAC_CODE_W-1:0] data_bus    // resolved lines
);
  logic       conv_clk_q; // converter clock one cycle ago
  logic [7:0] clk_rises;  // converter clock rises since start strobe ended
  // edge finder for the converter clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_clk_q <= 1'b0;
    end else begin
      conv_clk_q <= conv_clk;
    end
  end
  // saturating count, so a long idle spell never wraps back to a small value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_rises <= 8'h00;
    end else if (!wr_n) begin
      clk_rises <= 8'h00;
    end else if (conv_clk && !conv_clk_q && clk_rises != 8'hff) begin
      clk_rises <= clk_rises + 8'h01;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_oe_needs_sel: assert property (data_oe |-> $past(!cs_n && !rd_n, 2))
    else $error("data lines driven without select and read");
  chk_oe_on_read: assert property ((!cs_n && !rd_n) [*3] |-> data_oe)
    else $error("data lines not driven during read");
  chk_latch_on_done: assert property ($changed(data_out) |-> $fell(done_irq_n))
    else $error("output latch changed without completion");
  chk_read_stable: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("output latch moved during read");
  chk_start_clears: assert property ((!cs_n && !wr_n) [*4] |=> done_irq_n)
    else $error("start strobe did not clear completion");
  chk_conv_length: assert property (
    $rose(wr_n) && cs_n |-> ##[140:160] $fell(done_irq_n))
    else $error("completion not within expected span");
  chk_read_wait: assert property (
    $fell(rd_n) && !cs_n |-> clk_rises >= {1'b0, `SAC_HOST_WAIT})
    else $error("read before 74 converter clocks");
  chk_done_held: assert property (
    (cs_n || (rd_n && wr_n)) [*3] ##1 !done_irq_n |=> !done_irq_n)
    else $error("completion dropped without an access");
  cover property (!cs_n && !rd_n && data_oe && data_bus == data_out);
endmodule : sac_monitor

//--- verif/tb_sar_adc_conversion_control.sv
// self-checking bench: host and converter paired, plus a bench-driven converter
`timescale 1ns/1ps
`include "sac_map.svh"
module tb_sar_adc_conversion_control;
  import sac_pkg::*;
  localparam int HALF_NS = 25;     // 20 MHz system clock
  logic      clk_sys   = 1'b0;     // system clock
  logic      rst       = 1'b1;     // reset, held at start
  logic      start_req = 1'b0;     // host request
  logic      clk_sel   = 1'b0;     // paired converter clock source
  logic      ready;                // host idle
  logic      rd_valid;             // host read pulse
  logic      busy_a;               // paired converter busy
  logic      busy_b;               // bench-driven converter busy
  sac_code_t pos_a     = 8'h00;    // paired analog inputs
  sac_code_t neg_a     = 8'h00;
  sac_code_t pos_b     = 8'h00;    // bench-driven analog inputs
  sac_code_t neg_b     = 8'h00;
  sac_code_t rd_data;              // host read code
  sac_code_t result_a;             // paired latch copy
  sac_code_t result_b;             // bench-driven latch copy
  sac_code_t seen;                 // last code read by the bench
  sac_code_t rd_data_c;            // interrupt-driven host code
  sac_code_t rd_data_f;            // free-running host code
  logic      rd_valid_f;           // free-running host capture pulse
  int        fail_count  = 0;      // mismatches
  int        checks_done = 0;      // comparisons
  sac_code_t tp [5] = '{8'h00, 8'h80, 8'hff, 8'hfe, 8'h5a}; // positive levels
  sac_code_t tn [5] = '{8'h00, 8'h90, 8'h00, 8'h00, 8'h21}; // negative levels
  sac_bus_if bus_a ();             // host to converter
  sac_bus_if bus_b ();             // bench to converter, for aborts and stray strobes
  sac_bus_if bus_c ();             // interrupt-driven host to its converter
  sac_bus_if bus_f ();             // free-running host to its converter
  sac_host #(.CLK_HALF(1)) sac_host_i (.clk_sys, .rst, .bus(bus_a.host), .start_req,
    .ready, .rd_data, .rd_valid);
  sac_dev #(.RC_DIV(2)) sac_dev_i (.clk_sys, .rst, .bus(bus_a.dev), .analog_in_pos(pos_a),
    .analog_in_neg(neg_a), .clk_sel, .busy(busy_a), .result(result_a));
  sac_dev #(.RC_DIV(2)) sac_dev_fault_i (.clk_sys, .rst, .bus(bus_b.dev),
    .analog_in_pos(pos_b), .analog_in_neg(neg_b), .clk_sel(1'b1), .busy(busy_b),
    .result(result_b));
  // same requests as the paired host, but it reads on completion
  sac_host #(.CLK_HALF(1), .USE_IRQ(1'b1)) sac_host_irq_i (.clk_sys, .rst,
    .bus(bus_c.host), .start_req, .ready(), .rd_data(rd_data_c), .rd_valid());
  sac_dev #(.RC_DIV(2)) sac_dev_irq_i (.clk_sys, .rst, .bus(bus_c.dev),
    .analog_in_pos(pos_a), .analog_in_neg(neg_a), .clk_sel, .busy(), .result());
  // free-running wiring, started only by the power-up pulse
  sac_host #(.CLK_HALF(1), .FREE_RUN(1'b1)) sac_host_free_i (.clk_sys, .rst,
    .bus(bus_f.host), .start_req(1'b0), .ready(), .rd_data(rd_data_f),
    .rd_valid(rd_valid_f));
  sac_dev #(.RC_DIV(2)) sac_dev_free_i (.clk_sys, .rst, .bus(bus_f.dev),
    .analog_in_pos(pos_a), .analog_in_neg(neg_a), .clk_sel(1'b0), .busy(), .result());
  sac_monitor sac_monitor_i (.clk_sys, .rst, .cs_n(bus_a.cs_n), .wr_n(bus_a.wr_n),
    .rd_n(bus_a.rd_n), .conv_clk(bus_a.conv_clk), .done_irq_n(bus_a.done_irq_n),
    .data_oe(bus_a.data_oe), .data_out(bus_a.data_out), .data_bus(bus_a.data_bus));
  // free-running system clock
  always #HALF_NS clk_sys = ~clk_sys;
  // verdict and end of run
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // one comparison; x or z never counts as a match
  task automatic check(input string what, input sac_code_t got, input sac_code_t exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // ideal code of a clamped difference
  function automatic sac_code_t exp_code(input sac_code_t p, input sac_code_t n);
    return (p > n) ? p - n : 8'h00;
  endfunction : exp_code
  // host request for one conversion and read, through the paired bus
  task automatic convert_a(input sac_code_t p, input sac_code_t n, input logic sel);
    int k;
    @(posedge clk_sys);
    pos_a   <= p;
    neg_a   <= n;
    clk_sel <= sel;
    @(negedge clk_sys);
    for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clk_sys);
    @(posedge clk_sys);
    start_req <= 1'b1;
    @(posedge clk_sys);
    start_req <= 1'b0;
    // host waits the full converter count, so allow well over one conversion
    for (k = 0; k < 600 && rd_valid !== 1'b1; k++) @(negedge clk_sys);
    check("host read code", rd_data, exp_code(p, n));
    check("device latch", result_a, exp_code(p, n));
    // completion-driven host never reads later than the counting one
    check("irq host code", rd_data_c, exp_code(p, n));
    check("host ready", {7'h00, ready}, 8'h01);
    check("paired idle", {7'h00, busy_a}, 8'h00);
  endtask : convert_a
  // bench-side strobe on the second bus: write starts, read returns the lines
  task automatic strobe_b(input logic is_read, output sac_code_t got);
    @(posedge clk_sys);
    bus_b.cs_n <= 1'b0;
    if (is_read) begin
      bus_b.rd_n <= 1'b0;
    end else begin
      bus_b.wr_n <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    got = bus_b.data_bus;
    @(posedge clk_sys);
    bus_b.cs_n <= 1'b1;
    bus_b.rd_n <= 1'b1;
    bus_b.wr_n <= 1'b1;
  endtask : strobe_b
  // bounded wait for the second converter's completion
  task automatic wait_done_b;
    int k;
    for (k = 0; k < 400 && bus_b.done_irq_n !== 1'b0; k++) @(negedge clk_sys);
    check("completion b", {7'h00, bus_b.done_irq_n}, 8'h00);
  endtask : wait_done_b
  // hang guard: all tests need under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    bus_b.cs_n     = 1'b1;
    bus_b.wr_n     = 1'b1;
    bus_b.rd_n     = 1'b1;
    bus_b.conv_clk = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // back-to-back conversions, both clock sources, zero and full scale
    for (int i = 0; i < 5; i++) convert_a(tp[i], tn[i], i[0]);
    // baseline result on the bench-driven converter
    @(posedge clk_sys);
    pos_b <= 8'h10;
    strobe_b(1'b0, seen);
    wait_done_b();
    strobe_b(1'b1, seen);
    check("first read", seen, 8'h10);
    // read strobe without chip select must leave the lines floating
    @(posedge clk_sys);
    bus_b.rd_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("stray read", bus_b.data_bus, 8'hff);
    @(posedge clk_sys);
    bus_b.rd_n <= 1'b1;
    // start, abort in mid-conversion, restart
    pos_b <= 8'h77;
    strobe_b(1'b0, seen);
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check("busy mid conv", {7'h00, busy_b}, 8'h01);
    strobe_b(1'b0, seen);
    @(negedge clk_sys);
    check("latch after abort", result_b, 8'h10);
    // first conversion would have ended here; the restarted one must still run
    repeat (110) @(posedge clk_sys);
    @(negedge clk_sys);
    check("restart busy", {7'h00, busy_b}, 8'h01);
    check("restart no done", {7'h00, bus_b.done_irq_n}, 8'h01);
    strobe_b(1'b1, seen);
    check("old result kept", seen, 8'h10);
    wait_done_b();
    check("new latch", result_b, 8'h77);
    strobe_b(1'b1, seen);
    check("new read", seen, 8'h77);
    // free run: inputs have stood still for long, so take the second capture
    for (int j = 0; j < 2; j++) begin
      @(negedge clk_sys);
      for (int k = 0; k < 400 && rd_valid_f !== 1'b1; k++) @(negedge clk_sys);
    end
    check("free run valid", {7'h00, rd_valid_f}, 8'h01);
    check("free run code", rd_data_f, exp_code(tp[4], tn[4]));
    end_of_test();
  end
endmodule : tb_sar_adc_conversion_control
